// ===== verilog/bil_defines.vh
// Constants for the boot image locator and fault signal block
`ifndef BIL_DEFINES_VH
`define BIL_DEFINES_VH
// Register byte offsets
`define BIL_REG_CTRL 12'h000
`define BIL_REG_CAP 12'h004
`define BIL_REG_STATUS 12'h008
`define BIL_REG_LDR_ADDR 12'h00c
`define BIL_REG_SIG_ADDR 12'h010
`define BIL_REG_CPU_PLL 12'h014
`define BIL_REG_BUS_PLL 12'h018
`define BIL_REG_PER_PLL 12'h01c
`define BIL_REG_XTAL 12'h020
`define BIL_REG_CPU_FREQ 12'h024
`define BIL_REG_BUS_FREQ 12'h028
`define BIL_REG_PER_FREQ 12'h02c
`define BIL_REG_EVENT 12'h030
// Control fields
`define BIL_CTRL_MEDIUM_LSB 0
`define BIL_CTRL_BURST_LSB 4
`define BIL_CTRL_SECURE_BIT 6
`define BIL_CTRL_START_BIT 7
// Event register write bits
`define BIL_EV_ECC_BIT 0
`define BIL_EV_VERIFY_BIT 1
// Boot media
`define BIL_MED_SDMMC 3'h0
`define BIL_MED_SDHC 3'h1
`define BIL_MED_MNAND 3'h2
`define BIL_MED_NAND512 3'h3
`define BIL_MED_NAND2K 3'h4
`define BIL_MED_NAND4K 3'h5
// Burst modes
`define BIL_BURST_SINGLE 2'h0
`define BIL_BURST_4 2'h1
`define BIL_BURST_8 2'h2
// End-relative block offsets
`define BIL_SD_LDR_OFS 32'h0000_0012
`define BIL_SD_SIG_OFS 32'h0000_0002
`define BIL_HC_HIDDEN 32'h0000_0400
`define BIL_HC_LDR_OFS 32'h0000_0412
`define BIL_HC_SIG_OFS 32'h0000_0402
// Signature pages in block 0
`define BIL_SIG_PG_MNAND 32'h0000_0004
`define BIL_SIG_PG_N512 32'h0000_0010
`define BIL_SIG_PG_N2K 32'h0000_0004
`define BIL_SIG_PG_N4K 32'h0000_0002
`define BIL_LDR_BYTES 32'h0000_2000
// Fixed boot PLL settings
`define BIL_CPU_M 10'h0dc
`define BIL_CPU_P 6'h03
`define BIL_CPU_S 3'h2
`define BIL_BUS_M 10'h0dc
`define BIL_BUS_P 6'h03
`define BIL_BUS_S 3'h3
`define BIL_PER_M 10'h03c
`define BIL_PER_P 6'h02
`define BIL_PER_S 3'h4
`define BIL_PER_K 16'h0000
// Fault pattern timing
`define BIL_FAULT_PERIOD_US 1000
`define BIL_CLK_MHZ 100
`define BIL_FAULT_HI_PCT 90
`define BIL_FAULT_LO_PCT 10
`endif

// ===== verilog/bil_boot_locator.v
// Boot image locator, fixed boot PLL settings and fault indicator pattern
// How it works
// - SDHC size computed 1024 blocks short
// - NAND loader 8K from block 0 page 0
// - Managed NAND signature at page 4
// - 512-byte raw NAND signature at page 16
// - 2048-byte raw NAND signature at page 4
// - 4096-byte raw NAND signature at page 2
// - CPU PLL M220 P3 S2
// - Bus PLL M220 P3 S3
// - Peripheral PLL M60 P2 S4 K0
// - Integer PLL out is M*Fin/(P*2^S)
// - Peripheral PLL adds K/2^16 to M
// - ECC error: 90% high fault toggle
// - Secure verify fail: 10% high toggle
// - Managed NAND single, 4 or 8 bursts
`timescale 1ns/10ps
`default_nettype none
`include "bil_defines.vh"
module bil_boot_locator #(
  parameter FAULT_PERIOD = `BIL_FAULT_PERIOD_US * `BIL_CLK_MHZ
) (
  input wire i_clk,
  input wire i_srst,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hsel,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  input wire i_ecc_fail,
  input wire i_verify_fail,
  output wire o_fault_indicator_pin,
  output wire o_fault_indicator_pin_oe_n,
  output wire o_boot_done,
  output wire o_jump_en,
  output wire [1:0] o_burst_mode
);
  // Pattern lengths in clock cycles
  localparam [31:0] PERIOD = FAULT_PERIOD;
  localparam [31:0] HI_CYC = (PERIOD * `BIL_FAULT_HI_PCT) / 100;
  localparam [31:0] LO_CYC = PERIOD - HI_CYC;
  // Latched fault kind
  localparam [1:0] F_NONE = 2'h0;
  localparam [1:0] F_ECC = 2'h1;
  localparam [1:0] F_VERIFY = 2'h2;

  // Fault inputs come from outside logic, two flops each
  // A pulse shorter than one clock may be missed
  wire [1:0] async_in = {i_verify_fail, i_ecc_fail};
  wire [1:0] async_s;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      reg [1:0] sync_q;
      always @(posedge i_clk) begin
        if (i_srst)
          sync_q <= 2'h0;
        else
          sync_q <= {sync_q[0], async_in[g]};
      end
      assign async_s[g] = sync_q[1];
    end
  endgenerate
  wire ecc_s = async_s[0];
  wire ver_s = async_s[1];

  // AHB-Lite address phase capture
  reg wr_q;
  reg rd_q;
  reg [11:0] addr_q;
  // Only NONSEQ or SEQ transfers are taken
  wire take = i_hsel & i_hready & i_htrans[1];
  always @(posedge i_clk) begin
    if (i_srst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q <= take & i_hwrite;
      rd_q <= take & ~i_hwrite;
      if (take)
        addr_q <= i_haddr[11:0];
    end
  end

  // Zero wait states, every transfer ends in its data phase
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Software control and capacity registers
  reg [2:0] medium_q;
  reg [1:0] burst_q;
  reg secure_q;
  reg start_q;
  reg [31:0] cap_q;
  reg [7:0] xtal_q;
  reg [1:0] sw_fault_q;

  always @(posedge i_clk) begin
    if (i_srst) begin
      medium_q <= `BIL_MED_SDMMC;
      burst_q <= `BIL_BURST_SINGLE;
      secure_q <= 1'b0;
      start_q <= 1'b0;
      cap_q <= 32'h0000_0000;
      xtal_q <= 8'h0c;
      sw_fault_q <= 2'h0;
    end else begin
      // Event bits last one cycle, a write pulses them
      sw_fault_q <= 2'h0;
      if (wr_q) begin
        case (addr_q)
          `BIL_REG_CTRL: begin
            medium_q <= i_hwdata[`BIL_CTRL_MEDIUM_LSB +: 3];
            // A reserved burst code keeps the current mode
            if (i_hwdata[`BIL_CTRL_BURST_LSB +: 2] != 2'h3)
              burst_q <= i_hwdata[`BIL_CTRL_BURST_LSB +: 2];
            secure_q <= i_hwdata[`BIL_CTRL_SECURE_BIT];
            start_q <= i_hwdata[`BIL_CTRL_START_BIT];
          end
          `BIL_REG_CAP: cap_q <= i_hwdata;
          `BIL_REG_XTAL: xtal_q <= i_hwdata[7:0];
          `BIL_REG_EVENT: sw_fault_q <= i_hwdata[1:0];
          default: ;
        endcase
      end
    end
  end
  assign o_burst_mode = burst_q;

  // Location arithmetic
  // Both SD flavours count back from the last usable block
  // Capacity must be above the reserved tail or the offsets wrap
  wire [31:0] last_blk = cap_q - 32'h0000_0001;
  wire [31:0] hc_last = last_blk - `BIL_HC_HIDDEN;
  reg [31:0] ldr_addr;
  reg [31:0] sig_addr;
  always @* begin
    ldr_addr = 32'h0000_0000;
    sig_addr = 32'h0000_0000;
    case (medium_q)
      `BIL_MED_SDMMC: begin
        ldr_addr = last_blk - `BIL_SD_LDR_OFS;
        sig_addr = last_blk - `BIL_SD_SIG_OFS;
      end
      `BIL_MED_SDHC: begin
        ldr_addr = hc_last - `BIL_SD_LDR_OFS;
        sig_addr = hc_last - `BIL_SD_SIG_OFS;
      end
      // NAND media keep the loader at block 0 page 0
      `BIL_MED_MNAND: sig_addr = `BIL_SIG_PG_MNAND;
      `BIL_MED_NAND512: sig_addr = `BIL_SIG_PG_N512;
      `BIL_MED_NAND2K: sig_addr = `BIL_SIG_PG_N2K;
      `BIL_MED_NAND4K: sig_addr = `BIL_SIG_PG_N4K;
      default: ;
    endcase
  end

  // Locations latch once on start; a new run needs reset
  reg [31:0] ldr_q;
  reg [31:0] sig_q;
  reg done_q;
  always @(posedge i_clk) begin
    if (i_srst) begin
      ldr_q <= 32'h0000_0000;
      sig_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (start_q & ~done_q) begin
      ldr_q <= ldr_addr;
      sig_q <= sig_addr;
      done_q <= 1'b1;
    end
  end

  // Fixed PLL fields, index 0 cpu, 1 main bus, 2 peripheral
  // Fixed settings only; the loader must set the PLLs it needs
  wire [9:0] pll_m [0:2];
  wire [5:0] pll_p [0:2];
  wire [2:0] pll_s [0:2];
  wire [15:0] pll_k [0:2];
  assign pll_m[0] = `BIL_CPU_M;
  assign pll_p[0] = `BIL_CPU_P;
  assign pll_s[0] = `BIL_CPU_S;
  assign pll_k[0] = 16'h0000;
  assign pll_m[1] = `BIL_BUS_M;
  assign pll_p[1] = `BIL_BUS_P;
  assign pll_s[1] = `BIL_BUS_S;
  assign pll_k[1] = 16'h0000;
  assign pll_m[2] = `BIL_PER_M;
  assign pll_p[2] = `BIL_PER_P;
  assign pll_s[2] = `BIL_PER_S;
  assign pll_k[2] = `BIL_PER_K;

  // Output frequency in kHz; integer PLLs have a zero fraction
  wire [41:0] xtal_khz = {34'h0, xtal_q} * 42'd1000;
  wire [18:0] pll_word [0:2];
  wire [31:0] pll_freq [0:2];
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pll
      wire [57:0] num = {16'h0, xtal_khz} * {32'h0, pll_m[g], pll_k[g]};
      wire [57:0] den = {52'h0, pll_p[g]} << pll_s[g];
      wire [57:0] quo = (num >> 16) / den;
      assign pll_word[g] = {pll_m[g], pll_p[g], pll_s[g]};
      assign pll_freq[g] = quo[31:0];
    end
  endgenerate

  // Fault capture: first fault wins and latches
  // ECC wins when both arrive together; verify counts in secure mode only
  reg [1:0] fault_q;
  always @(posedge i_clk) begin
    if (i_srst)
      fault_q <= F_NONE;
    else if (fault_q == F_NONE) begin
      if (ecc_s | sw_fault_q[`BIL_EV_ECC_BIT])
        fault_q <= F_ECC;
      else if (secure_q &
               (ver_s | sw_fault_q[`BIL_EV_VERIFY_BIT]))
        fault_q <= F_VERIFY;
    end
  end

  // Pattern generator repeats forever once a fault latches
  reg [31:0] cnt_q;
  reg pin_q;
  // High length picks the duty for the latched fault kind
  wire [31:0] hi_len = (fault_q == F_ECC) ? HI_CYC : LO_CYC;
  always @(posedge i_clk) begin
    if (i_srst)
      cnt_q <= 32'h0000_0000;
    else if (fault_q != F_NONE) begin
      if (cnt_q == PERIOD - 32'h0000_0001)
        cnt_q <= 32'h0000_0000;
      else
        cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // Pin follows the counter one cycle later
  always @(posedge i_clk) begin
    if (i_srst)
      pin_q <= 1'b0;
    else if (fault_q != F_NONE)
      pin_q <= (cnt_q < hi_len);
  end

  // Pin is driven only while a fault pattern runs
  assign o_fault_indicator_pin = pin_q;
  assign o_fault_indicator_pin_oe_n = (fault_q == F_NONE);
  assign o_boot_done = done_q;
  // No jump to the loader once a fault has latched
  assign o_jump_en = done_q & (fault_q == F_NONE);

  // Read-back images of control and status
  wire [31:0] ctrl_rd = {24'h0, start_q, secure_q, burst_q, 1'b0, medium_q};
  wire [31:0] stat_rd = {28'h0, pin_q, fault_q, done_q};

  // Read mux
  reg [31:0] rd_d;
  reg [31:0] rdata_q;
  always @* begin
    case (addr_q)
      `BIL_REG_CTRL: rd_d = ctrl_rd;
      `BIL_REG_CAP: rd_d = cap_q;
      `BIL_REG_STATUS: rd_d = stat_rd;
      `BIL_REG_LDR_ADDR: rd_d = ldr_q;
      `BIL_REG_SIG_ADDR: rd_d = sig_q;
      `BIL_REG_CPU_PLL: rd_d = {13'h0, pll_word[0]};
      `BIL_REG_BUS_PLL: rd_d = {13'h0, pll_word[1]};
      `BIL_REG_PER_PLL: rd_d = {13'h0, pll_word[2]};
      `BIL_REG_XTAL: rd_d = {24'h0, xtal_q};
      `BIL_REG_CPU_FREQ: rd_d = pll_freq[0];
      `BIL_REG_BUS_FREQ: rd_d = pll_freq[1];
      `BIL_REG_PER_FREQ: rd_d = pll_freq[2];
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data stands in the data phase, then holds until the next read is taken, which clears it
  always @(posedge i_clk) begin
    if (i_srst)
      rdata_q <= 32'h0000_0000;
    else if (take & ~i_hwrite)
      rdata_q <= 32'h0000_0000;
    else if (rd_q)
      rdata_q <= rd_d;
  end
  assign o_hrdata = rd_q ? rd_d : rdata_q;
endmodule // bil_boot_locator
`default_nettype wire

// ===== sim/bil_chk.sv
// Assertions on the fault pattern and boot outputs
`timescale 1ns/10ps
`default_nettype none
module bil_chk #(parameter FAULT_PERIOD = 100) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic o_fault_indicator_pin,
  input wire logic o_fault_indicator_pin_oe_n,
  input wire logic o_boot_done,
  input wire logic o_jump_en,
  input wire logic [1:0] o_burst_mode
);
  localparam int HI = FAULT_PERIOD * 90 / 100;
  localparam int LO = FAULT_PERIOD * 10 / 100;
  wire logic pin = o_fault_indicator_pin;
  wire logic drv = !o_fault_indicator_pin_oe_n;
  int hi_q = 0;
  int lo_q = 0;
  // Length of the current high and driven low stretches
  always @(posedge i_clk) begin
    hi_q <= (pin && !i_srst) ? hi_q + 1 : 0;
    lo_q <= (!pin && drv && !i_srst) ? lo_q + 1 : 0;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  duty_fall_a: assert property ($fell(pin) && drv |->
    (hi_q == HI || hi_q == LO)) else $error("fault duty wrong");
  high_len_a: assert property (hi_q <= HI)
    else $error("fault pin high too long");
  low_len_a: assert property (lo_q <= HI)
    else $error("fault pin low too long");
  fault_hold_a: assert property (drv |=> drv && !o_jump_en)
    else $error("fault pattern stopped");
  pin_quiet_a: assert property (!drv |-> !pin)
    else $error("pin high while undriven");
  jump_gate_a: assert property (o_jump_en |-> o_boot_done && !drv)
    else $error("jump without clean boot");
  done_hold_a: assert property (o_boot_done |=> o_boot_done)
    else $error("boot done dropped");
  burst_legal_a: assert property (o_burst_mode != 2'h3)
    else $error("illegal burst mode");
  cover property ($fell(pin) && hi_q == HI);
  cover property ($fell(pin) && hi_q == LO);
  cover property ($rose(o_boot_done));
endmodule // bil_chk
bind bil_boot_locator bil_chk #(.FAULT_PERIOD(FAULT_PERIOD)) bil_chk_inst (
  .i_clk, .i_srst, .o_fault_indicator_pin, .o_fault_indicator_pin_oe_n,
  .o_boot_done, .o_jump_en, .o_burst_mode);
`default_nettype wire

// ===== sim/bil_stor_model.sv
// Boot storage model raising read faults on request
`timescale 1ns/10ps
`default_nettype none
module bil_stor_model (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  output logic o_ecc_fail = 1'b0,
  output logic o_verify_fail = 1'b0
);
  always @(posedge i_clk) begin
    o_ecc_fail <= i_mode == 2'h1;
    o_verify_fail <= i_mode == 2'h2;
  end
endmodule // bil_stor_model
`default_nettype wire

// ===== sim/tb_bil_boot_locator.sv
// Self-checking bench for the boot image locator
`timescale 1ns/10ps
`default_nettype none
`include "bil_defines.vh"
module tb_bil_boot_locator;
  logic i_clk = 0, i_srst = 1, i_hwrite = 0;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, cap, rd;
  logic [1:0] i_htrans = 0, mode = 0, o_burst_mode;
  logic o_hreadyout, o_hresp, ecc, ver, pin, oe_n, done, jump;
  int errors = 0, total_checks = 0, cyc = 0;
  int mv[3] = '{220, 220, 60};
  int pv[3] = '{3, 3, 2};
  int sv[3] = '{2, 3, 4};
  always #5 i_clk = ~i_clk;
  bil_boot_locator #(.FAULT_PERIOD(100)) bil_boot_locator_inst (
    .i_clk, .i_srst, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2),
    .i_hwdata, .i_hsel(1'b1), .i_hready(o_hreadyout), .o_hrdata,
    .o_hreadyout, .o_hresp, .i_ecc_fail(ecc), .i_verify_fail(ver),
    .o_fault_indicator_pin(pin), .o_fault_indicator_pin_oe_n(oe_n),
    .o_boot_done(done), .o_jump_en(jump), .o_burst_mode);
  bil_stor_model bil_stor_model_inst (.i_clk, .i_mode(mode),
    .o_ecc_fail(ecc), .o_verify_fail(ver));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_haddr <= {20'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  task rst;
    i_srst <= 1'b1;
    mode <= 2'h0;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
  endtask
  function automatic logic [31:0] loc(int m, logic [31:0] c, bit s);
    if (m > 1) return s ? ((m == 3) ? 16 : (m == 5) ? 2 : 4) : 0;
    return c - 1 - ((m == 1) ? 1024 : 0) - (s ? 2 : 18);
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_clk) if (++cyc == 30000) begin
    errors++;
    give_verdict();
  end
  initial begin
    cap = $urandom(32'hc5a78f32);
    for (int m = 0; m < 6; m++) begin
      rst();
      cap = 32'h800 + $urandom % 32'h10000;
      bus(1'b1, `BIL_REG_CAP, cap);
      bus(1'b1, `BIL_REG_CTRL, 32'h80 | (m % 3) << 4 | m);
      bus(1'b0, `BIL_REG_LDR_ADDR, 0);
      chk(rd, loc(m, cap, 0));
      bus(1'b0, `BIL_REG_SIG_ADDR, 0);
      chk(rd, loc(m, cap, 1));
      chk({o_hresp, o_burst_mode}, m % 3);
      chk({done, jump}, 2'h3);
      $display("medium %0d done", m);
    end
    for (int x = 12; x <= 24; x += 12) begin
      if (x == 24) bus(1'b1, `BIL_REG_XTAL, 24);
      for (int i = 0; i < 3; i++) begin
        bus(1'b0, 12'(`BIL_REG_CPU_PLL + 4 * i), 0);
        chk(rd, {10'(mv[i]), 6'(pv[i]), 3'(sv[i])});
        bus(1'b0, 12'(`BIL_REG_CPU_FREQ + 4 * i), 0);
        chk(rd, mv[i] * x * 1000 / (pv[i] << sv[i]));
      end
    end
    bus(1'b1, `BIL_REG_CTRL, 32'hb5);
    @(posedge i_clk);
    chk(o_burst_mode, `BIL_BURST_8);
    bus(1'b0, 12'h040, 0);
    chk(rd, 0);
    $display("pll and map test done");
    rst();
    mode <= 2'h1;
    repeat (250) @(posedge i_clk);
    mode <= 2'h2;
    bus(1'b1, `BIL_REG_CTRL, 32'hc0);
    bus(1'b0, `BIL_REG_STATUS, 0);
    chk(rd[2:1], 1);
    chk({oe_n, jump}, 0);
    rst();
    bus(1'b1, `BIL_REG_CTRL, 32'hc0);
    mode <= 2'h2;
    repeat (250) @(posedge i_clk);
    bus(1'b0, `BIL_REG_STATUS, 0);
    chk(rd[2:1], 2);
    rst();
    mode <= 2'h2;
    repeat (20) @(posedge i_clk);
    chk(oe_n, 1);
    bus(1'b1, `BIL_REG_EVENT, 1);
    repeat (150) @(posedge i_clk);
    bus(1'b0, `BIL_REG_STATUS, 0);
    chk(rd[2:1], 1);
    $display("fault test done");
    give_verdict();
  end
endmodule // tb_bil_boot_locator
`default_nettype wire
